// >>> verilog/ceu_top.sv
// ceu_top: exception entry sequencing with an APB register window
// assumes: core pulses instr_end at each instruction end and pulses the
// abort and decode inputs in the same pclk domain; request pins are async
//
// Functional notes
// - entry loads the fixed vector of the exception; 0x14 is never used
// - entry mode: supervisor, undefined, abort, normal or fast interrupt mode
// - fixed priority: reset, data abort, fast, normal, prefetch, undef or trap
// - undefined instruction and software trap never flagged from the same cycle
// - data abort with fast interrupt enabled chains straight to the fast vector
// - enabled fast interrupt latency at most 28 cycles
// - after worst latency the fast vector instruction is executing
// - minimum interrupt latency is sync plus fast entry, 4 cycles
// - normal interrupt may wait without bound while fast ones run
// - while reset is low, fetch from incrementing word addresses
// - reset release copies pc and status into supervisor link and saved
// - reset release sets supervisor mode, both masks, clears compact bit
// - after reset release fetch from zero in native state
// - with fast mask clear, fast request is sampled every instruction end
// - each entry saves return address and status into the new mode
`timescale 1ns/10ps
`include "ceu_map.svh"
module ceu_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic core_reset_low,
  input wire logic fast_int_request_low,
  input wire logic normal_int_request_low,
  input wire logic instr_end,
  input wire logic data_abort,
  input wire logic prefetch_abort,
  input wire logic undef_decode,
  input wire logic software_trap,
  output logic [31:0] fetch_addr,
  output ceu_pkg::ceu_status_t current_status_word,
  output logic entry_busy,
  output logic vector_load
);
  import ceu_pkg::*;

  logic [2:0] pins_sync;
  logic rst_held;
  logic fiq_low;
  logic irq_low;
  ceu_state_e state_r;
  logic [1:0] cnt_r;
  logic [31:0] pc_r;
  ceu_status_t status_r;
  logic [31:0] link_r [0:4];
  ceu_status_t saved_r [0:4];
  logic [31:0] retoff_r [0:4];
  logic dabt_p_r, pabt_p_r, und_p_r, trap_p_r;
  logic boundary, fiq_req, irq_req, take;
  ceu_kind_e kind;
  logic [31:0] vec;
  logic [4:0] new_mode;
  logic [2:0] new_idx, cur_idx;
  logic [1:0] entry_len;
  logic [31:0] link_off;
  logic wr_en, rd_setup, ret_req;

  ceu_sync #(.W(3)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in({core_reset_low, fast_int_request_low, normal_int_request_low}),
    .pin_sync(pins_sync)
  );
  assign rst_held = ~pins_sync[2];
  assign fiq_low = ~pins_sync[1];
  assign irq_low = ~pins_sync[0];

  function automatic logic [2:0] mode_idx(input logic [4:0] m);
    case (m)
      `CEU_MODE_UND: mode_idx = 3'h1;
      `CEU_MODE_ABT: mode_idx = 3'h2;
      `CEU_MODE_IRQ: mode_idx = 3'h3;
      `CEU_MODE_FIQ: mode_idx = 3'h4;
      default: mode_idx = 3'h0;
    endcase
  endfunction : mode_idx

  // an entry ending is itself a boundary, so a held fast request chains at once
  assign boundary = ((state_r == CEU_ST_RUN) & instr_end) |
                    ((state_r == CEU_ST_ENTRY) & (cnt_r == 2'h1));
  assign fiq_req = fiq_low & ~status_r[`CEU_SW_F];
  assign irq_req = irq_low & ~status_r[`CEU_SW_I];

  // one winner per boundary; a lower request simply stays pending
  always_comb begin
    kind = CEU_K_NONE;
    if (dabt_p_r) begin
      kind = CEU_K_DABT;
    end else if (fiq_req) begin
      kind = CEU_K_FIQ;
    end else if (irq_req) begin
      kind = CEU_K_IRQ;
    end else if (pabt_p_r) begin
      kind = CEU_K_PABT;
    end else if (und_p_r) begin
      kind = CEU_K_UND;
    end else if (trap_p_r) begin
      kind = CEU_K_TRAP;
    end
  end
  assign take = boundary & (kind != CEU_K_NONE) & ~rst_held;

  always_comb begin
    vec = `CEU_VEC_RESET;
    new_mode = `CEU_MODE_SVC;
    entry_len = `CEU_T_FIQ_CYC;
    link_off = `CEU_LINK_OFF_STD;
    case (kind)
      CEU_K_DABT: begin
        vec = `CEU_VEC_DABT;
        new_mode = `CEU_MODE_ABT;
        entry_len = `CEU_T_EXC_CYC;
        link_off = `CEU_LINK_OFF_DABT;
      end
      CEU_K_FIQ: begin
        vec = `CEU_VEC_FIQ;
        new_mode = `CEU_MODE_FIQ;
      end
      CEU_K_IRQ: begin
        vec = `CEU_VEC_IRQ;
        new_mode = `CEU_MODE_IRQ;
      end
      CEU_K_PABT: begin
        vec = `CEU_VEC_PABT;
        new_mode = `CEU_MODE_ABT;
      end
      CEU_K_UND: begin
        vec = `CEU_VEC_UND;
        new_mode = `CEU_MODE_UND;
      end
      CEU_K_TRAP: begin
        vec = `CEU_VEC_TRAP;
        new_mode = `CEU_MODE_SVC;
      end
      default: begin
        vec = `CEU_VEC_RESET;
      end
    endcase
  end
  assign new_idx = mode_idx(new_mode);
  assign cur_idx = mode_idx(status_r[4:0]);

  assign wr_en = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign ret_req = wr_en & (paddr == `CEU_OFF_RET) & pwdata[0];

  // sequencer; reset pin outranks everything
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= CEU_ST_RST;
      cnt_r <= 2'h0;
    end else begin
      case (state_r)
        CEU_ST_RUN: begin
          if (rst_held) begin
            state_r <= CEU_ST_RST;
          end else if (take) begin
            state_r <= CEU_ST_ENTRY;
            cnt_r <= entry_len;
          end
        end
        CEU_ST_RST: begin
          if (!rst_held) begin
            state_r <= CEU_ST_RUN;
          end
        end
        CEU_ST_ENTRY: begin
          if (rst_held) begin
            state_r <= CEU_ST_RST;
          end else if (take) begin
            cnt_r <= entry_len;
          end else if (cnt_r == 2'h1) begin
            state_r <= CEU_ST_RUN;
          end else begin
            cnt_r <= cnt_r - 2'h1;
          end
        end
        default: begin
          state_r <= CEU_ST_RST;
        end
      endcase
    end
  end

  // fetch address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_r <= `CEU_VEC_RESET;
    end else if (state_r == CEU_ST_RST) begin
      if (rst_held) begin
        pc_r <= pc_r + 32'h4;
      end else begin
        pc_r <= `CEU_VEC_RESET;
      end
    end else if (rst_held) begin
      pc_r <= pc_r + 32'h4;
    end else if (take) begin
      pc_r <= vec;
    end else if (ret_req) begin
      pc_r <= link_r[cur_idx] - retoff_r[cur_idx];
    end else if ((state_r == CEU_ST_RUN) & instr_end) begin
      pc_r <= pc_r + 32'h4;
    end
  end

  // status word: entry beats a software write in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_r <= `CEU_SW_RESET;
    end else if (state_r == CEU_ST_RST) begin
      if (!rst_held) begin
        status_r[4:0] <= `CEU_MODE_SVC;
        status_r[`CEU_SW_I] <= 1'b1;
        status_r[`CEU_SW_F] <= 1'b1;
        status_r[`CEU_SW_T] <= 1'b0;
      end
    end else if (take) begin
      status_r[4:0] <= new_mode;
      status_r[`CEU_SW_T] <= 1'b0;
      status_r[`CEU_SW_I] <= 1'b1;
      if (kind == CEU_K_FIQ) begin
        status_r[`CEU_SW_F] <= 1'b1;
      end
    end else if (ret_req) begin
      status_r <= saved_r[cur_idx];
    end else if (wr_en & (paddr == `CEU_OFF_STATUS)) begin
      status_r <= pwdata[7:0];
    end
  end

  // banked link and saved status, one entry per exception mode
  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : g_bank
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          link_r[g] <= 32'h0;
          saved_r[g] <= 8'h0;
          retoff_r[g] <= 32'h0;
        end else if ((state_r == CEU_ST_RST) & !rst_held & (g == 0)) begin
          link_r[g] <= pc_r;
          saved_r[g] <= status_r;
          retoff_r[g] <= 32'h0;
        end else if (take & (new_idx == 3'(g))) begin
          link_r[g] <= pc_r + link_off;
          saved_r[g] <= status_r;
          retoff_r[g] <= link_off;
        end
      end
    end
  endgenerate

  // pending core events: a new event in the clearing cycle is kept
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dabt_p_r <= 1'b0;
      pabt_p_r <= 1'b0;
      und_p_r <= 1'b0;
      trap_p_r <= 1'b0;
    end else if (rst_held) begin
      dabt_p_r <= 1'b0;
      pabt_p_r <= 1'b0;
      und_p_r <= 1'b0;
      trap_p_r <= 1'b0;
    end else begin
      dabt_p_r <= data_abort | (dabt_p_r & ~(take & (kind == CEU_K_DABT)));
      pabt_p_r <= prefetch_abort | (pabt_p_r & ~(take & (kind == CEU_K_PABT)));
      // trap decode wins a same-cycle decode clash; an older pending undefined flag is kept
      und_p_r <= (undef_decode & ~software_trap) |
                 (und_p_r & ~(take & (kind == CEU_K_UND)));
      trap_p_r <= software_trap | (trap_p_r & ~(take & (kind == CEU_K_TRAP)));
    end
  end

  // apb read data captured in setup, so the access phase needs no wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (rd_setup) begin
      case (paddr)
        `CEU_OFF_STATUS: prdata <= {24'h0, status_r};
        `CEU_OFF_PC: prdata <= pc_r;
        `CEU_OFF_LINK: prdata <= link_r[cur_idx];
        `CEU_OFF_SAVED: prdata <= {24'h0, saved_r[cur_idx]};
        `CEU_OFF_PEND: prdata <= {25'h0, state_r, dabt_p_r, pabt_p_r, und_p_r, trap_p_r};
        default: prdata <= 32'h0;
      endcase
    end
  end

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~((paddr == `CEU_OFF_STATUS) | (paddr == `CEU_OFF_PC) |
                   (paddr == `CEU_OFF_LINK) | (paddr == `CEU_OFF_SAVED) |
                   (paddr == `CEU_OFF_PEND) | (paddr == `CEU_OFF_RET));
  assign fetch_addr = pc_r;
  assign current_status_word = status_r;
  assign entry_busy = (state_r == CEU_ST_ENTRY);
  assign vector_load = take;

  chk_vector_fiq: assert property (@(posedge pclk) disable iff (!presetn)
    take && kind == CEU_K_FIQ |=> pc_r == `CEU_VEC_FIQ && !rst_held || rst_held)
    else $error("fast entry did not load its vector");
  chk_no_reserved: assert property (@(posedge pclk) disable iff (!presetn)
    take |=> pc_r != `CEU_VEC_RSVD)
    else $error("reserved vector loaded");
  chk_abort_mode: assert property (@(posedge pclk) disable iff (!presetn)
    take && (kind == CEU_K_DABT || kind == CEU_K_PABT) && !rst_held |=>
    status_r[4:0] == `CEU_MODE_ABT || rst_held)
    else $error("abort entry mode wrong");
  chk_dabt_first: assert property (@(posedge pclk) disable iff (!presetn)
    take && dabt_p_r |-> kind == CEU_K_DABT)
    else $error("data abort lost priority");
  // flags from different instructions may both pend; only a same-cycle clash is barred
  chk_decode_excl: assert property (@(posedge pclk) disable iff (!presetn)
    undef_decode && software_trap && !und_p_r |=> !und_p_r)
    else $error("undefined latched together with trap");
  chk_chain_fiq: assert property (@(posedge pclk) disable iff (!presetn)
    take && kind == CEU_K_DABT && fiq_req ##1 !rst_held [*3] |->
    (take && kind == CEU_K_FIQ) || !fiq_req)
    else $error("fast interrupt not chained after data abort");
  chk_fiq_entry_len: assert property (@(posedge pclk) disable iff (!presetn)
    take && kind == CEU_K_FIQ ##1 !rst_held [*2] |-> boundary && pc_r == `CEU_VEC_FIQ)
    else $error("fast entry time wrong");
  chk_fiq_sampled: assert property (@(posedge pclk) disable iff (!presetn)
    boundary && fiq_req && !rst_held |-> take && (kind == CEU_K_FIQ || kind == CEU_K_DABT))
    else $error("enabled fast request not taken at boundary");
  chk_irq_yields: assert property (@(posedge pclk) disable iff (!presetn)
    take && kind == CEU_K_IRQ |-> !fiq_req)
    else $error("normal interrupt beat fast interrupt");
  chk_reset_fetch: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == CEU_ST_RST && rst_held |=> pc_r == $past(pc_r) + 32'h4)
    else $error("reset fetch not incrementing");
  chk_reset_release: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == CEU_ST_RST && !rst_held |=> pc_r == `CEU_VEC_RESET &&
    status_r[4:0] == `CEU_MODE_SVC && status_r[`CEU_SW_I] && status_r[`CEU_SW_F] &&
    !status_r[`CEU_SW_T] && link_r[0] == $past(pc_r) && saved_r[0] == $past(status_r))
    else $error("reset release sequence wrong");
  chk_save_status: assert property (@(posedge pclk) disable iff (!presetn)
    take && !rst_held && kind == CEU_K_IRQ |=> saved_r[3] == $past(status_r))
    else $error("status not saved on entry");
  cov_chain: cover property (@(posedge pclk) disable iff (!presetn)
    take && kind == CEU_K_DABT ##3 take && kind == CEU_K_FIQ);
  cov_irq: cover property (@(posedge pclk) disable iff (!presetn) take && kind == CEU_K_IRQ);
  cov_release: cover property (@(posedge pclk) disable iff (!presetn)
    state_r == CEU_ST_RST ##1 state_r == CEU_ST_RUN);
  cov_return: cover property (@(posedge pclk) disable iff (!presetn) ret_req);
endmodule : ceu_top

// >>> verilog/ceu_map.svh
// ceu_map.svh: vectors, mode codes, status word fields, register offsets, entry timing
// assumes: included by the exception entry top module and its bench
`ifndef CEU_MAP_SVH
`define CEU_MAP_SVH
`define CEU_VEC_RESET 32'h0000_0000
`define CEU_VEC_UND 32'h0000_0004
`define CEU_VEC_TRAP 32'h0000_0008
`define CEU_VEC_PABT 32'h0000_000c
`define CEU_VEC_DABT 32'h0000_0010
`define CEU_VEC_RSVD 32'h0000_0014
`define CEU_VEC_IRQ 32'h0000_0018
`define CEU_VEC_FIQ 32'h0000_001c
`define CEU_MODE_USR 5'h10
`define CEU_MODE_FIQ 5'h11
`define CEU_MODE_IRQ 5'h12
`define CEU_MODE_SVC 5'h13
`define CEU_MODE_ABT 5'h17
`define CEU_MODE_UND 5'h1b
`define CEU_SW_T 5
`define CEU_SW_F 6
`define CEU_SW_I 7
`define CEU_SW_RESET 8'hd3
`define CEU_OFF_STATUS 12'h000
`define CEU_OFF_PC 12'h004
`define CEU_OFF_LINK 12'h008
`define CEU_OFF_SAVED 12'h00c
`define CEU_OFF_PEND 12'h010
`define CEU_OFF_RET 12'h014
`define CEU_T_SYNC_MAX_CYC 3
`define CEU_T_LDM_CYC 20
`define CEU_T_EXC_CYC 2'h3
`define CEU_T_FIQ_CYC 2'h2
`define CEU_T_MIN_CYC 4
`define CEU_T_WORST_CYC 28
`define CEU_LINK_OFF_DABT 32'h0000_0008
`define CEU_LINK_OFF_STD 32'h0000_0004
`endif

// >>> verilog/ceu_pkg.sv
// ceu_pkg: types of the exception entry unit
// assumes: ceu_map.svh holds every number
package ceu_pkg;
  typedef enum logic [2:0] {
    CEU_ST_RUN = 3'h1,
    CEU_ST_RST = 3'h2,
    CEU_ST_ENTRY = 3'h4
  } ceu_state_e;
  typedef enum logic [2:0] {
    CEU_K_NONE = 3'h0,
    CEU_K_DABT = 3'h1,
    CEU_K_FIQ = 3'h2,
    CEU_K_IRQ = 3'h3,
    CEU_K_PABT = 3'h4,
    CEU_K_UND = 3'h5,
    CEU_K_TRAP = 3'h6
  } ceu_kind_e;
  typedef logic [7:0] ceu_status_t;
endpackage : ceu_pkg

// >>> verilog/ceu_sync.sv
// ceu_sync: two-flop synchroniser for asynchronous active-low pins
// assumes: inputs come from outside the pclk domain; idle level is high
`timescale 1ns/10ps
module ceu_sync #(
  parameter int W = 3
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_sync
);
  logic [W-1:0] meta_r;
  // reset to idle-high so no request is seen while the chain fills
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= '1;
      pin_sync <= '1;
    end else begin
      meta_r <= pin_in;
      pin_sync <= meta_r;
    end
  end
endmodule : ceu_sync

// >>> tb/ceu_int_src_model.sv
// ceu_int_src_model: interrupt source driving the active-low request pins
// assumes: the bench raises and drops each request by level
`timescale 1ns/10ps
module ceu_int_src_model #(
  parameter int LAG = 0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic fast_on,
  input wire logic normal_on,
  output logic fast_int_request_low,
  output logic normal_int_request_low
);
  // lag lets the fast request line answer promptly or slowly; the normal line has no lag
  logic [7:0] fast_dly_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_dly_r <= 8'h00;
      fast_int_request_low <= 1'b1;
      normal_int_request_low <= 1'b1;
    end else begin
      fast_dly_r <= {fast_dly_r[6:0], fast_on};
      fast_int_request_low <= ~fast_dly_r[LAG];
      // normal line stays low until the bench marks it serviced
      normal_int_request_low <= ~normal_on;
    end
  end
endmodule : ceu_int_src_model

// >>> tb/tb_cpu_exception_entry_unit.sv
// tb_cpu_exception_entry_unit: self-checking bench of the exception entry unit
// assumes: ceu_top and the request source model are compiled first
`timescale 1ns/10ps
`include "ceu_map.svh"
module tb_cpu_exception_entry_unit;
  import ceu_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic core_reset_low = 1'b1;
  logic fast_on = 1'b0;
  logic normal_on = 1'b0;
  logic fast_int_request_low;
  logic normal_int_request_low;
  logic instr_end = 1'b0;
  logic [3:0] ev = 4'h0;
  logic [31:0] fetch_addr;
  ceu_status_t current_status_word;
  logic entry_busy;
  logic vector_load;
  int bad_count = 0;
  int checks = 0;
  always #10 pclk = ~pclk;
  ceu_top u_ceu_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .core_reset_low(core_reset_low),
    .fast_int_request_low(fast_int_request_low),
    .normal_int_request_low(normal_int_request_low), .instr_end(instr_end),
    .data_abort(ev[3]), .prefetch_abort(ev[2]), .undef_decode(ev[1]),
    .software_trap(ev[0]), .fetch_addr(fetch_addr),
    .current_status_word(current_status_word), .entry_busy(entry_busy),
    .vector_load(vector_load));
  ceu_int_src_model #(.LAG(0)) u_ceu_int_src_model (.pclk(pclk), .presetn(presetn),
    .fast_on(fast_on), .normal_on(normal_on), .fast_int_request_low(fast_int_request_low),
    .normal_int_request_low(normal_int_request_low));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
    output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic take(input logic [3:0] e, input logic [31:0] vec, input logic [4:0] mode);
    @(posedge pclk);
    ev <= e;
    @(posedge pclk);
    ev <= 4'h0;
    instr_end <= 1'b1;
    #1 chk("vector_load", 32'h1, {31'h0, vector_load});
    @(posedge pclk);
    instr_end <= 1'b0;
    #1 chk("fetch_addr", vec, fetch_addr);
    chk("mode", {27'h0, mode}, {27'h0, current_status_word[4:0]});
    chk("entry_busy", 32'h1, {31'h0, entry_busy});
    for (int i = 0; i < 12 && entry_busy !== 1'b0; i++) @(posedge pclk);
  endtask : take
  task automatic s_reset_and_apb();
    logic [31:0] d;
    logic e;
    chk("fetch_addr", `CEU_VEC_RESET, fetch_addr);
    chk("status", 32'hd3, {24'h0, current_status_word});
    apb(1'b0, `CEU_OFF_STATUS, 32'h0, d, e);
    chk("status read", 32'hd3, d);
    apb(1'b0, 12'h020, 32'h0, d, e);
    chk("unmapped err", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, d);
  endtask : s_reset_and_apb
  task automatic s_vectors();
    take(4'h8, `CEU_VEC_DABT, `CEU_MODE_ABT);
    take(4'h4, `CEU_VEC_PABT, `CEU_MODE_ABT);
    take(4'h2, `CEU_VEC_UND, `CEU_MODE_UND);
    take(4'h1, `CEU_VEC_TRAP, `CEU_MODE_SVC);
    take(4'h3, `CEU_VEC_TRAP, `CEU_MODE_SVC);
    take(4'h6, `CEU_VEC_PABT, `CEU_MODE_ABT);
  endtask : s_vectors
  task automatic s_fast_latency();
    logic [31:0] d;
    logic e;
    int n;
    apb(1'b1, `CEU_OFF_STATUS, 32'h13, d, e);
    @(posedge pclk);
    fast_on <= 1'b1;
    instr_end <= 1'b1;
    n = 0;
    while (n < 40 && fetch_addr !== `CEU_VEC_FIQ) begin
      @(posedge pclk);
      n++;
      #1;
    end
    chk("fast latency max", 32'h1, {31'h0, n <= `CEU_T_WORST_CYC});
    chk("fast latency min", 32'h1, {31'h0, n >= `CEU_T_MIN_CYC});
    chk("mode", `CEU_MODE_FIQ, {27'h0, current_status_word[4:0]});
    @(posedge pclk);
    fast_on <= 1'b0;
    instr_end <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask : s_fast_latency
  task automatic s_abort_with_fast();
    logic [31:0] d;
    logic e;
    apb(1'b1, `CEU_OFF_STATUS, 32'h13, d, e);
    fast_on <= 1'b1;
    repeat (4) @(posedge pclk);
    take(4'h8, `CEU_VEC_DABT, `CEU_MODE_ABT);
    #1 chk("chained vector", `CEU_VEC_FIQ, fetch_addr);
    fast_on <= 1'b0;
    apb(1'b0, `CEU_OFF_LINK, 32'h0, d, e);
    chk("fast link", `CEU_VEC_DABT + `CEU_LINK_OFF_STD, d);
    apb(1'b1, `CEU_OFF_RET, 32'h1, d, e);
    #1 chk("resume addr", `CEU_VEC_DABT, fetch_addr);
    chk("resume mode", `CEU_MODE_ABT, {27'h0, current_status_word[4:0]});
  endtask : s_abort_with_fast
  task automatic s_order();
    logic [31:0] d;
    logic e;
    apb(1'b1, `CEU_OFF_STATUS, 32'h13, d, e);
    fast_on <= 1'b1;
    normal_on <= 1'b1;
    repeat (4) @(posedge pclk);
    take(4'h0, `CEU_VEC_FIQ, `CEU_MODE_FIQ);
    fast_on <= 1'b0;
    apb(1'b1, `CEU_OFF_STATUS, 32'h13, d, e);
    repeat (4) @(posedge pclk);
    // normal entry masks itself, so the pending prefetch abort chains at its end
    take(4'h4, `CEU_VEC_IRQ, `CEU_MODE_IRQ);
    #1 chk("chained prefetch", `CEU_VEC_PABT, fetch_addr);
    chk("mode", {27'h0, `CEU_MODE_ABT}, {27'h0, current_status_word[4:0]});
    apb(1'b1, `CEU_OFF_STATUS, 32'h13, d, e);
    take(4'h0, `CEU_VEC_IRQ, `CEU_MODE_IRQ);
    normal_on <= 1'b0;
  endtask : s_order
  task automatic s_core_reset();
    logic [31:0] a;
    @(posedge pclk);
    core_reset_low <= 1'b0;
    repeat (4) @(posedge pclk);
    #1 a = fetch_addr;
    @(posedge pclk);
    #1 chk("reset fetch step", a + 32'h4, fetch_addr);
    @(posedge pclk);
    core_reset_low <= 1'b1;
    for (int i = 0; i < 8 && fetch_addr !== 32'h0; i++) @(posedge pclk);
    #1 chk("fetch_addr", `CEU_VEC_RESET, fetch_addr);
    chk("status", 32'hd3, {24'h0, current_status_word});
  endtask : s_core_reset
  task automatic print_verdict();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : print_verdict
  initial begin
    #100us;
    bad_count++;
    print_verdict();
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    #1 s_reset_and_apb();
    s_vectors();
    s_fast_latency();
    s_abort_with_fast();
    s_order();
    s_core_reset();
    print_verdict();
  end
endmodule : tb_cpu_exception_entry_unit
